// ==== design/clbc_bus_ctrl.sv ====
// top: minimum-mode local bus control sequencer
// Operation
// R1: idle bus yields during next clock
// R2: cycle within 3 clocks uses active rules
// R3: active cycle yields at T4 if conditions met
// R4: lock from prefix until next instruction ends
// R5: lock output floats while yield acknowledged
// R6: queue status shown clock after operation
// R7: queue codes nop, first, empty, subsequent
// R8: memory/io select valid T4 before to final T4; code only switches it on entry to T1
// R9: write strobe low T2, T3, wait
// R10: int ack strobe low T2, T3, wait
// R11: address latch high T1, never floated
// R12: direction high transmit, timed like select
// R13: transceiver enable spans cycle per direction
// R14: yield ack mid T1, bus floats together; code raises the ack on the edge ending T4 or an idle clock
// R15: drop ack on low request, resume when needed
// R16: requester supplies synchronous yield request
// R17: grant request recorded, held during lock
// R18: locked halt ignores yields, interrupt exits
// R19: interrupts deferred across prefixed instruction
// R20: repeated string interruptible, lock held; code drops the lock when the interrupt is taken
// R21: states T1, T2, T3, waits, T4
`timescale 1ns/1ps
module clbc_bus_ctrl (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cyc_req,
  input wire clbc_pkg::clbc_cyc_e i_cyc_type,
  input wire logic i_cyc_mem,
  input wire logic i_cyc_odd_low,
  input wire logic i_cyc_first_int_ack_strobe_n,
  input wire logic i_ready,
  input wire logic i_hold,
  input wire logic i_rq,
  input wire logic [1:0] i_queue_op,
  input wire logic i_lock_prefix,
  input wire logic i_prefix,
  input wire logic i_instr_done,
  input wire logic i_halt,
  input wire logic i_string_elem,
  input wire logic i_int_req,
  output logic o_cyc_busy,
  output logic o_int_take,
  output logic o_ale,
  output logic o_wr_n,
  output logic o_wr_oe,
  output logic o_int_ack_strobe_n,
  output logic o_mio,
  output logic o_mio_oe,
  output logic o_xcvr_direction,
  output logic o_xcvr_direction_oe,
  output logic o_xcvr_enable_n,
  output logic o_xcvr_enable_oe,
  output logic o_lock_n,
  output logic o_lock_oe,
  output logic o_bus_yield_ack,
  output logic o_grant,
  output logic [1:0] o_queue_state_code
);
  import clbc_pkg::*;

  clbc_lock_if lk ();
  clbc_state_e st_q;
  clbc_state_e st_d;
  clbc_cyc_e typ_q;
  logic mem_q;
  logic nosplit_q;
  logic hold_s1_q;
  logic hold_q;
  logic rq_s1_q;
  logic rq_q;
  logic early_q;
  logic [1:0] idle_cnt_q;
  logic rq_pend_q;
  logic int_take;
  logic yield_ok;

  // command strobes share one span: t2, t3 and waits [R9] [R10]
  function automatic logic strobe_span(input clbc_state_e s);
    return s == CLBC_T2 || s == CLBC_T3 || s == CLBC_TW;
  endfunction

  // =====================================
  // pin synchronisers
  // request is meant to be synchronous, but a second stage adds just one clock of latency [R16]
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hold_s1_q <= 1'b0;
      hold_q <= 1'b0;
      rq_s1_q <= 1'b0;
      rq_q <= 1'b0;
    end else if (i_ce) begin
      hold_s1_q <= i_hold;
      hold_q <= hold_s1_q;
      rq_s1_q <= i_rq;
      rq_q <= rq_s1_q;
    end
  end

  // =====================================
  // lock tracker
  clbc_lock_track u_lock (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_lock_prefix(i_lock_prefix),
    .i_prefix(i_prefix),
    .i_instr_done(i_instr_done),
    .i_halt(i_halt),
    .i_string_elem(i_string_elem),
    .i_int_taken(int_take),
    .lk(lk)
  );

  assign int_take = i_int_req && !lk.int_hold_off; // [R19] [R20]
  // locked halt ignores yields; lock blocks release conditions [R3] [R18]
  assign yield_ok = hold_q && !lk.locked && !lk.lock_halt;

  // =====================================
  // early request tracking
  // a request seen before T2, or on an idle bus within 3 clocks, counts
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      early_q <= 1'b0;
      idle_cnt_q <= 2'h0;
    end else if (i_ce) begin
      if (st_q == CLBC_TI && hold_q && idle_cnt_q != 2'(CLBC_IDLE_WINDOW)) begin
        idle_cnt_q <= idle_cnt_q + 2'h1; // [R2]
      end else if (!hold_q) begin
        idle_cnt_q <= 2'h0;
      end
      if (!hold_q) begin
        early_q <= 1'b0;
      // an idle request only counts as early within its window
      end else if ((st_q == CLBC_TI && idle_cnt_q != 2'(CLBC_IDLE_WINDOW))
                   || st_q == CLBC_T1) begin
        early_q <= 1'b1; // before T2, or idle-window start [R2] [R3]
      end
    end
  end

  // =====================================
  // state sequencing
  always_comb begin
    st_d = st_q;
    case (st_q)
      CLBC_TI: begin
        if (yield_ok && !i_cyc_req) begin
          st_d = CLBC_TH; // [R1]
        end else if (i_cyc_req) begin
          st_d = CLBC_T1; // [R21]
        end
      end
      CLBC_T1: st_d = CLBC_T2; // [R21]
      CLBC_T2: st_d = CLBC_T3;
      CLBC_T3: st_d = i_ready ? CLBC_T4 : CLBC_TW; // [R21]
      CLBC_TW: st_d = i_ready ? CLBC_T4 : CLBC_TW;
      CLBC_T4: begin
        if (yield_ok && early_q && nosplit_q) begin
          st_d = CLBC_TH; // [R3] [R2]
        end else if (i_cyc_req) begin
          st_d = CLBC_T1;
        end else begin
          st_d = CLBC_TI;
        end
      end
      CLBC_TH: begin
        if (!hold_q) begin
          st_d = CLBC_TI; // [R15]
        end
      end
      default: st_d = CLBC_TI;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= CLBC_TI;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  // cycle attributes captured on entry to T1
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      typ_q <= CLBC_CYC_READ;
      mem_q <= 1'b1;
      nosplit_q <= 1'b1;
    end else if (i_ce && st_d == CLBC_T1 && st_q != CLBC_T1) begin
      typ_q <= i_cyc_type;
      mem_q <= i_cyc_mem;
      nosplit_q <= !i_cyc_odd_low && !i_cyc_first_int_ack_strobe_n; // [R3]
    end
  end

  // =====================================
  // strobes, registered from next state so outputs are flops
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ale <= 1'b0;
      o_wr_n <= 1'b1;
      o_int_ack_strobe_n <= 1'b1;
      o_xcvr_enable_n <= 1'b1;
      o_mio <= 1'b1;
      o_xcvr_direction <= 1'b0;
    end else if (i_ce) begin
      o_ale <= (st_d == CLBC_T1); // [R11]
      // write strobe uses captured type, valid from T2
      o_wr_n <= !(strobe_span(st_d) && typ_q == CLBC_CYC_WRITE); // [R9]
      o_int_ack_strobe_n <= !(strobe_span(st_d) && typ_q == CLBC_CYC_INT_ACK_STROBE_N); // [R10]
      // clock-grained: write from T2 on, read/ack from T3, off at T4 [R13]
      o_xcvr_enable_n <= !(((st_d == CLBC_T2) && typ_q == CLBC_CYC_WRITE)
                           || st_d == CLBC_T3 || st_d == CLBC_TW);
      // select and direction update on entry to T1, not at the preceding T4 [R8] [R12]
      if (st_d == CLBC_T1 && st_q != CLBC_T1) begin
        o_mio <= i_cyc_mem; // [R8]
        o_xcvr_direction <= (i_cyc_type == CLBC_CYC_WRITE); // [R12]
      end
    end
  end

  // =====================================
  // float control and yield acknowledge
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_bus_yield_ack <= 1'b0;
      o_wr_oe <= 1'b1;
      o_mio_oe <= 1'b1;
      o_xcvr_direction_oe <= 1'b1;
      o_xcvr_enable_oe <= 1'b1;
      o_lock_oe <= 1'b1;
    end else if (i_ce) begin
      // ack and float assert together on one edge [R14]
      o_bus_yield_ack <= (st_d == CLBC_TH); // [R14] [R15]
      // lines stay floating after the yield until a cycle needs them [R15]
      if (st_d == CLBC_TH) begin
        o_wr_oe <= 1'b0; // [R9]
        o_mio_oe <= 1'b0; // [R8]
        o_xcvr_direction_oe <= 1'b0; // [R12]
        o_xcvr_enable_oe <= 1'b0; // [R13]
      end else if (st_d == CLBC_T1) begin
        o_wr_oe <= 1'b1; // [R15]
        o_mio_oe <= 1'b1;
        o_xcvr_direction_oe <= 1'b1;
        o_xcvr_enable_oe <= 1'b1;
      end
      // lock floats only while acknowledged, so a lock prefix arriving during the yield is left floating
      o_lock_oe <= (st_d != CLBC_TH); // [R5]
    end
  end

  // =====================================
  // lock output, grant, queue status, interrupt take
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_lock_n <= 1'b1;
      rq_pend_q <= 1'b0;
      o_grant <= 1'b0;
      o_queue_state_code <= CLBC_QS_NOP;
      o_int_take <= 1'b0;
      o_cyc_busy <= 1'b0;
    end else if (i_ce) begin
      o_lock_n <= !(lk.locked || i_lock_prefix); // [R4] [R20]
      // request recorded while locked, grant withheld [R17]
      if (rq_q) begin
        rq_pend_q <= 1'b1;
      end else if (o_grant) begin
        rq_pend_q <= 1'b0;
      end
      o_grant <= (rq_q || rq_pend_q) && !lk.locked && !o_grant; // [R17] [R18]
      o_queue_state_code <= i_queue_op; // one clock after the operation [R6] [R7]
      o_int_take <= int_take; // [R19]
      o_cyc_busy <= (st_d != CLBC_TI && st_d != CLBC_TH);
    end
  end
endmodule

// ==== design/clbc_lock_if.sv ====
// interface: lock state shared between bus sequencer and lock tracker
`timescale 1ns/1ps
interface clbc_lock_if;
  logic locked;
  logic lock_halt;
  logic int_hold_off;
  modport tracker (output locked, output lock_halt, output int_hold_off);
  modport user (input locked, input lock_halt, input int_hold_off);
endinterface

// ==== design/clbc_lock_track.sv ====
// lock and prefix tracker: lock span, locked halt, interrupt deferral
`timescale 1ns/1ps
module clbc_lock_track (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_lock_prefix,
  input wire logic i_prefix,
  input wire logic i_instr_done,
  input wire logic i_halt,
  input wire logic i_string_elem,
  input wire logic i_int_taken,
  clbc_lock_if.tracker lk
);
  logic lock_q;
  logic pend_q;
  logic pfx_q;
  logic halt_q;
  // =====================================
  // lock span
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lock_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (i_ce) begin
      if (i_lock_prefix) begin
        lock_q <= 1'b1; // [R4]
        pend_q <= 1'b1;
      end else if (i_int_taken) begin
        lock_q <= 1'b0; // a taken interrupt drops lock, string op or locked halt, unless a lock prefix arrives in the same clock [R20]
        pend_q <= 1'b0;
      end else if (pend_q && i_instr_done) begin
        lock_q <= 1'b0; // held to end of next instruction [R4]
        pend_q <= 1'b0;
      end
    end
  end
  // =====================================
  // prefix deferral and halt
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pfx_q <= 1'b0;
      halt_q <= 1'b0;
    end else if (i_ce) begin
      if (i_prefix || i_lock_prefix) begin
        pfx_q <= 1'b1;
      end else if (i_instr_done) begin
        pfx_q <= 1'b0;
      end
      if (i_int_taken) begin
        halt_q <= 1'b0; // interrupt leaves halt even when locked [R18]
      end else if (i_halt) begin
        halt_q <= 1'b1;
      end
    end
  end
  assign lk.locked = lock_q;
  assign lk.lock_halt = lock_q && halt_q; // [R18]
  // halt and string elements may take interrupts mid-instruction [R19] [R20]
  // the prefix byte itself defers too, not only the bytes after it
  assign lk.int_hold_off = (pfx_q || i_prefix || i_lock_prefix) && !halt_q && !i_string_elem
                           && !i_halt; // [R19]
endmodule

// ==== design/clbc_pkg.sv ====
// package: constants and types for the local bus control block
package clbc_pkg;
  localparam int CLBC_CLK_MHZ = 20;
  localparam int CLBC_IDLE_WINDOW = 3;
  localparam logic [1:0] CLBC_QS_NOP = 2'h0;
  localparam logic [1:0] CLBC_QS_FIRST = 2'h1;
  localparam logic [1:0] CLBC_QS_EMPTY = 2'h2;
  localparam logic [1:0] CLBC_QS_NEXT = 2'h3;
  typedef enum logic [2:0] {
    CLBC_TI = 3'b000,
    CLBC_T1 = 3'b001,
    CLBC_T2 = 3'b010,
    CLBC_T3 = 3'b011,
    CLBC_TW = 3'b100,
    CLBC_T4 = 3'b101,
    CLBC_TH = 3'b110
  } clbc_state_e;
  typedef enum logic [1:0] {
    CLBC_CYC_READ = 2'b00,
    CLBC_CYC_WRITE = 2'b01,
    CLBC_CYC_INT_ACK_STROBE_N = 2'b10
  } clbc_cyc_e;
endpackage

// ==== testbench/clbc_bus_ctrl_properties.sv ====
// checker: strobe timing, queue status and bus yield assertions
`timescale 1ns/1ps
module clbc_bus_ctrl_chk (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_hold,
  input wire logic [1:0] i_queue_op,
  input wire logic o_ale,
  input wire logic o_wr_n,
  input wire logic o_wr_oe,
  input wire logic o_int_ack_strobe_n,
  input wire logic o_mio,
  input wire logic o_mio_oe,
  input wire logic o_xcvr_direction,
  input wire logic o_xcvr_enable_n,
  input wire logic o_lock_oe,
  input wire logic o_bus_yield_ack,
  input wire logic [1:0] o_queue_state_code
);
  // ==========================================
  // properties
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_wr_start;
    o_ale ##1 $fell(o_wr_n);
  endsequence
  a_ale_one_cycle: assert property (o_ale |=> !o_ale)
    else $error("ale longer than one clock");
  a_strobes_off_t1: assert property (o_ale |-> o_wr_n && o_int_ack_strobe_n)
    else $error("strobe active in t1");
  a_wr_spans_t3: assert property (s_wr_start |=> !o_wr_n)
    else $error("write strobe dropped before t3");
  a_wr_start_t2: assert property ($fell(o_wr_n) |-> $past(o_ale) && !o_xcvr_enable_n
    && o_xcvr_direction)
    else $error("write strobe start wrong");
  a_int_ack_strobe_n_start_t2: assert property ($fell(o_int_ack_strobe_n) |-> $past(o_ale)
    && o_xcvr_enable_n && !o_xcvr_direction ##1 !o_xcvr_enable_n)
    else $error("int ack strobe start wrong");
  a_select_stable: assert property (o_ale |=> $stable(o_mio) && $stable(o_xcvr_direction))
    else $error("select moved after t1");
  a_ack_floats: assert property (o_bus_yield_ack |-> !(o_wr_oe | o_mio_oe | o_lock_oe))
    else $error("line driven during yield");
  a_qs_follows_op: assert property (!$past(i_rst) && $past(i_ce)
    |-> o_queue_state_code == $past(i_queue_op))
    else $error("queue status wrong");
  a_yield_cause: assert property ($rose(o_bus_yield_ack) |-> $past(i_hold, 2))
    else $error("yield without request");
  a_ack_release: assert property (!i_hold [*4] |=> !o_bus_yield_ack)
    else $error("yield ack kept");
  a_float_until_t1: assert property ($rose(o_mio_oe) |-> o_ale)
    else $error("lines driven before a cycle");
endmodule
bind clbc_bus_ctrl clbc_bus_ctrl_chk u_chk (.*);

// ==== testbench/clbc_bus_ctrl_tb_top.sv ====
// testbench: cycle table, queue codes, yield, lock and interrupt deferral
`timescale 1ns/1ps
module clbc_bus_ctrl_tb_top;
  import clbc_pkg::*;
  typedef struct packed {
    clbc_cyc_e ty;
    logic mem;
    logic [1:0] w;
    logic [2:0] wr;
    logic [2:0] ia;
    logic [2:0] en;
  } clbc_row_s;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_cyc_req = 1'b0, i_cyc_mem = 1'b0;
  logic i_ready, i_hold, i_rq = 1'b0, i_lock_prefix = 1'b0, i_prefix = 1'b0;
  logic i_instr_done = 1'b0, i_int_req = 1'b0, hold_want = 1'b0, got;
  logic i_cyc_odd_low = 1'b0, i_cyc_first_int_ack_strobe_n = 1'b0, i_halt = 1'b0, i_string_elem = 1'b0;
  logic [1:0] i_queue_op = 2'h0, waits = 2'h0;
  clbc_cyc_e i_cyc_type = CLBC_CYC_READ;
  logic o_cyc_busy, o_int_take, o_ale, o_wr_n, o_wr_oe, o_int_ack_strobe_n, o_mio, o_mio_oe;
  logic o_xcvr_direction, o_xcvr_direction_oe, o_xcvr_enable_n, o_xcvr_enable_oe, o_lock_n;
  logic o_lock_oe, o_bus_yield_ack, o_grant;
  logic [1:0] o_queue_state_code;
  logic [2:0] nwr, nia, nen;
  int err_total = 0, check_count = 0;
  clbc_row_s rows [5] = '{'{CLBC_CYC_READ, 1'b1, 2'h0, 3'h0, 3'h0, 3'h1},
    '{CLBC_CYC_WRITE, 1'b0, 2'h0, 3'h2, 3'h0, 3'h2}, '{CLBC_CYC_WRITE, 1'b1, 2'h2, 3'h4, 3'h0, 3'h4},
    '{CLBC_CYC_INT_ACK_STROBE_N, 1'b0, 2'h1, 3'h0, 3'h3, 3'h2}, '{CLBC_CYC_READ, 1'b0, 2'h2, 3'h0, 3'h0, 3'h3}};
  clbc_bus_ctrl dut (.*);
  clbc_far_model far (.i_mclk, .i_rst, .i_ale(o_ale), .i_waits(waits), .i_want_hold(hold_want),
    .o_ready(i_ready), .o_hold(i_hold));
  // ==========================================
  // helpers
  initial forever #25 i_mclk = ~i_mclk;
  task automatic tick();
    @(posedge i_mclk);
    #5;
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic till(ref logic s);
    for (int n = 0; n < 12 && s !== 1'b1; n++) tick();
  endtask
  task automatic pulse_done();
    i_instr_done = 1'b1;
    tick();
    i_instr_done = 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // run needs a few hundred clocks; 3000 leaves margin
  initial begin
    #(50 * 3000);
    err_total++;
    wrap_up();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (20) @(posedge i_mclk);
    #5 i_rst = 1'b0;
    chk(o_ale === 1'b0 && o_wr_n === 1'b1 && o_queue_state_code === 2'h0, "reset");
    foreach (rows[k]) begin
      i_cyc_type = rows[k].ty;
      {i_cyc_mem, waits} = {rows[k].mem, rows[k].w};
      i_cyc_req = 1'b1;
      till(o_ale);
      i_cyc_req = 1'b0;
      {nwr, nia, nen} = 9'h0;
      tick();
      chk(o_mio === rows[k].mem && o_xcvr_direction === rows[k].ty[0], "select");
      repeat (7) begin
        {nwr, nia, nen} = {nwr + {2'h0, ~o_wr_n}, nia + {2'h0, ~o_int_ack_strobe_n},
          nen + {2'h0, ~o_xcvr_enable_n}};
        tick();
      end
      chk({nwr, nia, nen} === {rows[k].wr, rows[k].ia, rows[k].en}, "strobes");
    end
    // back to back: t4 straight into t1
    i_cyc_type = CLBC_CYC_WRITE;
    {waits, i_cyc_req, nwr} = {2'h0, 1'b1, 3'h0};
    till(o_ale);
    repeat (9) begin
      nwr = nwr + {2'h0, o_ale};
      tick();
    end
    i_cyc_req = 1'b0;
    chk(nwr === 3'h3, "back to back");
    repeat (6) tick();
    for (int q = 0; q < 4; q++) begin
      i_queue_op = 2'(q);
      tick();
      chk(o_queue_state_code === 2'(q), "queue code");
    end
    i_queue_op = 2'h0;
    hold_want = 1'b1;
    till(o_bus_yield_ack);
    chk(o_bus_yield_ack === 1'b1 && o_wr_oe === 1'b0 && o_lock_oe === 1'b0, "yield");
    {i_cyc_req, hold_want} = 2'h2;
    till(o_ale);
    chk(o_bus_yield_ack === 1'b0 && o_ale === 1'b1 && o_mio_oe === 1'b1, "resume");
    i_cyc_req = 1'b0;
    repeat (6) tick();
    // odd low byte and first ack cycles keep the bus; a plain cycle yields at t4
    i_cyc_type = CLBC_CYC_READ;
    {i_cyc_odd_low, i_cyc_req, hold_want, got} = 4'he;
    repeat (12) begin
      tick();
      got = got | o_bus_yield_ack;
    end
    {i_cyc_odd_low, i_cyc_first_int_ack_strobe_n} = 2'h1;
    repeat (12) begin
      tick();
      got = got | o_bus_yield_ack;
    end
    chk(got === 1'b0, "split cycle yielded");
    i_cyc_first_int_ack_strobe_n = 1'b0;
    till(o_bus_yield_ack);
    chk(o_bus_yield_ack === 1'b1 && o_xcvr_enable_oe === 1'b0, "active yield");
    {i_cyc_req, hold_want} = 2'h0;
    repeat (8) tick();
    chk(o_bus_yield_ack === 1'b0 && o_wr_oe === 1'b0 && o_mio_oe === 1'b0, "float idle");
    {i_lock_prefix, i_prefix, i_rq, got} = 4'he;
    tick();
    {i_lock_prefix, i_prefix, i_rq} = 3'h0;
    repeat (8) begin
      tick();
      got = got | o_grant;
    end
    chk(o_lock_n === 1'b0 && got === 1'b0, "lock span");
    pulse_done();
    till(o_grant);
    chk(o_grant === 1'b1 && o_lock_n === 1'b1, "grant after lock");
    {i_prefix, i_int_req} = 2'h3;
    tick();
    got = o_int_take;
    i_prefix = 1'b0;
    repeat (3) begin
      tick();
      got = got | o_int_take;
    end
    chk(got === 1'b0, "int in prefix");
    pulse_done();
    till(o_int_take);
    chk(o_int_take === 1'b1, "int after instr");
    i_int_req = 1'b0;
    // locked halt ignores the yield request until an interrupt ends it
    {i_lock_prefix, i_halt, hold_want, got} = 4'he;
    tick();
    {i_lock_prefix, i_halt} = 2'h0;
    repeat (8) begin
      tick();
      got = got | o_bus_yield_ack;
    end
    chk(got === 1'b0 && o_lock_n === 1'b0, "locked halt yielded");
    i_int_req = 1'b1;
    till(o_bus_yield_ack);
    i_int_req = 1'b0;
    chk(o_bus_yield_ack === 1'b1 && o_lock_oe === 1'b0, "halt exit");
    hold_want = 1'b0;
    repeat (6) tick();
    // a locked string run holds the lock until an element takes an interrupt, which drops the lock
    {i_lock_prefix, i_string_elem} = 2'h3;
    tick();
    i_lock_prefix = 1'b0;
    repeat (4) tick();
    chk(o_lock_n === 1'b0, "string lock dropped");
    i_int_req = 1'b1;
    tick();
    chk(o_int_take === 1'b1, "string not interruptible");
    {i_int_req, i_string_elem} = 2'h0;
    pulse_done();
    wrap_up();
  end
endmodule

// ==== testbench/clbc_far_model.sv ====
// far side: ready responder with wait states and a yield requester
`timescale 1ns/1ps
module clbc_far_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ale,
  input wire logic [1:0] i_waits,
  input wire logic i_want_hold,
  output logic o_ready,
  output logic o_hold
);
  // ==========================================
  // responder
  logic [2:0] cnt_q;
  always_ff @(posedge i_mclk) cnt_q <= (i_rst | i_ale) ? 3'h0 : cnt_q + {2'h0, cnt_q != 3'h7};
  // slow device: ready withheld i_waits clocks past t3
  assign o_ready = cnt_q > {1'b0, i_waits};
  // request changes on the clock only, held until withdrawn
  always_ff @(posedge i_mclk) o_hold <= i_want_hold;
endmodule
